// >>> io_space_params.svh
// constants for the peripheral register space decoder
// assumes inclusion by the decoder files and the bench only, not by io_space_pkg.sv
`ifndef IO_SPACE_PARAMS_SVH
`define IO_SPACE_PARAMS_SVH
`define IO_PORT_LAST      6'h3F
`define IO_BIT_LAST       6'h1F
`define IO_DATA_OFFSET    16'h0020
`define IO_DATA_FIRST     16'h0020
`define IO_DATA_LAST      16'h005F
`define EXT_IO_FIRST      16'h0060
`define EXT_IO_LAST       16'h00FF
`define SRAM_FIRST        16'h0100
`define SRAM_LAST         16'h04FF
`define SRAM_LAST_COMPAT  16'h045F
`define RESET_BYTE        8'h00
`define RESET_ADDR        16'h0000
`endif

// >>> io_space_pkg.sv
// types shared by the peripheral space decoder
// assumes io_space_params.svh is on the include path
package io_space_pkg;
    typedef enum logic [2:0] {
        OP_NONE     = 3'h0,
        OP_LOAD     = 3'h1,
        OP_STORE    = 3'h2,
        OP_PORT_IN  = 3'h3,
        OP_PORT_OUT = 3'h4,
        OP_BIT_SET  = 3'h5,
        OP_BIT_CLR  = 3'h6,
        OP_BIT_TEST = 3'h7
    } access_op_t;

    typedef struct packed {
        access_op_t  op;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic [2:0]  bitSel;
    } core_req_t;

    typedef enum logic [2:0] {
        TGT_NONE = 3'h0,
        TGT_IO   = 3'h1,
        TGT_EXTIO= 3'h2,
        TGT_SRAM = 3'h3,
        TGT_EXTERNAL_MEMORY_BUS = 3'h4
    } target_t;

    typedef struct packed {
        target_t     tgt;
        logic [7:0]  ioIndex;
        logic [15:0] memAddr;
    } decode_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b11
    } rmw_state_t;
endpackage : io_space_pkg

// >>> io_addr_decode.sv
// combinational map from a core access to its target space
// assumes io_space_params.svh; pure logic, no clock
`timescale 1ns/1ps
`include "io_space_params.svh"
module io_addr_decode (
    input  io_space_pkg::core_req_t req,
    input  wire logic               compatMode,
    input  wire logic               xmemEnable,
    output io_space_pkg::decode_t   dec
);
    // data-space address of the access, port forms shifted up
    logic [15:0] dataAddr;
    logic        portForm;
    always_comb begin
        portForm = (req.op == io_space_pkg::OP_PORT_IN) || (req.op == io_space_pkg::OP_PORT_OUT)
                || (req.op == io_space_pkg::OP_BIT_SET) || (req.op == io_space_pkg::OP_BIT_CLR)
                || (req.op == io_space_pkg::OP_BIT_TEST);
        dataAddr = portForm ? {10'h000, req.addr[5:0]} + `IO_DATA_OFFSET : req.addr;
    end

    // target selection
    always_comb begin
        dec.tgt     = io_space_pkg::TGT_NONE;
        dec.ioIndex = 8'h00;
        dec.memAddr = dataAddr;
        if (req.op == io_space_pkg::OP_NONE) begin
            dec.tgt = io_space_pkg::TGT_NONE;
        end else if (portForm && req.addr[15:6] != 10'h000) begin
            dec.tgt = io_space_pkg::TGT_NONE;
        end else if (portForm && req.op != io_space_pkg::OP_PORT_IN
                     && req.op != io_space_pkg::OP_PORT_OUT
                     && req.addr[5:0] > `IO_BIT_LAST) begin
            dec.tgt = io_space_pkg::TGT_NONE;
        end else if (dataAddr >= `IO_DATA_FIRST && dataAddr <= `IO_DATA_LAST) begin
            dec.tgt     = io_space_pkg::TGT_IO;
            dec.ioIndex = 8'(dataAddr - `IO_DATA_OFFSET);
        end else if (dataAddr >= `EXT_IO_FIRST && dataAddr <= `EXT_IO_LAST) begin
            // only the data forms get here: port forms top out below it
            if (compatMode) begin
                dec.tgt = io_space_pkg::TGT_SRAM;
            end else begin
                dec.tgt     = io_space_pkg::TGT_EXTIO;
                dec.ioIndex = 8'(dataAddr - `IO_DATA_OFFSET);
            end
        end else if (dataAddr >= `SRAM_FIRST
                     && dataAddr <= (compatMode ? `SRAM_LAST_COMPAT : `SRAM_LAST)) begin
            dec.tgt = io_space_pkg::TGT_SRAM;
        end else if (dataAddr < `IO_DATA_FIRST) begin
            dec.tgt = io_space_pkg::TGT_NONE;
        end else if (xmemEnable) begin
            dec.tgt = io_space_pkg::TGT_EXTERNAL_MEMORY_BUS;
        end else begin
            dec.tgt = io_space_pkg::TGT_NONE;
        end
    end
endmodule : io_addr_decode

// >>> io_space_decoder.sv
// peripheral register space decoder with bit and flag handling
// assumes a core presenting one request per cycle while reqReady is high
//
// Behaviour
// - every peripheral register is reachable by data loads and stores at its data-space address.
// - single-bit set and clear act on port addresses 0 to 0x1F and nowhere else.
// - in that lower window the skip tests can examine any one bit of a register.
// - port in and out use port addresses 0 to 0x3F, the 64 opcode-encodable locations.
// - a peripheral reached over the data path sits at its port address plus 0x20.
// - the extended window 0x60 to 0xFF is reachable only by data loads and stores.
// - in legacy compatibility mode the extended window maps onto plain data memory.
// - some status flags clear on writing one and ignore writing zero.
// - bit set and clear do a whole-register read-modify-write, clearing set flags.
// - with the external bus on, addresses beyond internal memory go to the external pins.
// - with the external bus off, such addresses never alias onto internal memory.
`timescale 1ns/1ps
`include "io_space_params.svh"
module io_space_decoder (
    input  wire logic               clk_sys,
    input  wire logic               rst_b,
    input  io_space_pkg::core_req_t req,
    input  wire logic               reqValid,
    input  wire logic               compatMode,
    input  wire logic               xmemEnable,
    input  wire logic [7:0]         ioRdata,
    input  wire logic               ioPresent,
    input  wire logic [7:0]         w1cMask,
    input  wire logic [7:0]         sramRdata,
    input  wire logic [7:0]         xmemRdata,
    output logic                    reqReady,
    output logic                    rspValid,
    output logic [7:0]              rspData,
    output logic                    rspBitTrue,
    output logic                    ioRead,
    output logic                    ioWrite,
    output logic [7:0]              ioIndex,
    output logic [7:0]              ioWdata,
    output logic                    sramRead,
    output logic                    sramWrite,
    output logic                    xmemRead,
    output logic                    xmemWrite,
    output logic [15:0]             memAddr,
    output logic [7:0]              memWdata
);
    io_space_pkg::decode_t dec;

    io_addr_decode decodeInst (
        .req        (req),
        .compatMode (compatMode),
        .xmemEnable (xmemEnable),
        .dec        (dec)
    );

    // write-back value of a bit operation; flags read as one go back as one
    function automatic logic [7:0] bitMerge(input logic [7:0] cur,
                                            input logic [2:0] sel,
                                            input logic       setIt);
        logic [7:0] m;
        m = 8'h01 << sel;
        bitMerge = setIt ? (cur | m) : (cur & ~m);
    endfunction : bitMerge

    io_space_pkg::rmw_state_t state_q, state_d;
    logic [7:0]  rmwData_q, rmwData_d;
    logic [2:0]  rmwBit_q, rmwBit_d;
    logic        rmwSet_q, rmwSet_d;
    logic [7:0]  rmwIdx_q, rmwIdx_d;
    logic        rspValid_d, rspBitTrue_d, ioRead_d, ioWrite_d;
    logic        sramRead_d, sramWrite_d, xmemRead_d, xmemWrite_d;
    logic [7:0]  rspData_d, ioIndex_d, ioWdata_d, memWdata_d;
    logic [15:0] memAddr_d;
    logic        pendRd_q, pendRd_d;
    logic        pendTest_q, pendTest_d;
    io_space_pkg::target_t pendTgt_q, pendTgt_d;
    logic [2:0]  pendBit_q, pendBit_d;

    // read-modify-write sequencer and strobe generation
    always_comb begin
        state_d      = state_q;
        rmwData_d    = rmwData_q;
        rmwBit_d     = rmwBit_q;
        rmwSet_d     = rmwSet_q;
        rmwIdx_d     = rmwIdx_q;
        pendRd_d     = 1'b0;
        pendTest_d   = 1'b0;
        pendTgt_d    = pendTgt_q;
        pendBit_d    = pendBit_q;
        rspValid_d   = 1'b0;
        rspData_d    = `RESET_BYTE;
        rspBitTrue_d = 1'b0;
        ioRead_d     = 1'b0;
        ioWrite_d    = 1'b0;
        sramRead_d   = 1'b0;
        sramWrite_d  = 1'b0;
        xmemRead_d   = 1'b0;
        xmemWrite_d  = 1'b0;
        ioIndex_d    = ioIndex;
        ioWdata_d    = ioWdata;
        memAddr_d    = memAddr;
        memWdata_d   = memWdata;
        // returning read data from the previous cycle's strobe
        if (pendRd_q) begin
            rspValid_d = 1'b1;
            unique case (pendTgt_q)
                io_space_pkg::TGT_IO,
                io_space_pkg::TGT_EXTIO: rspData_d = ioPresent ? ioRdata : `RESET_BYTE;
                io_space_pkg::TGT_SRAM:  rspData_d = sramRdata;
                io_space_pkg::TGT_EXTERNAL_MEMORY_BUS:  rspData_d = xmemRdata;
                default:                 rspData_d = `RESET_BYTE;
            endcase
            rspBitTrue_d = pendTest_q & rspData_d[pendBit_q];
        end
        unique case (state_q)
            io_space_pkg::ST_IDLE: begin
                if (reqValid && !pendRd_q) begin
                    ioIndex_d  = dec.ioIndex;
                    memAddr_d  = dec.memAddr;
                    ioWdata_d  = req.wdata;
                    memWdata_d = req.wdata;
                    unique case (req.op)
                        io_space_pkg::OP_LOAD, io_space_pkg::OP_PORT_IN,
                        io_space_pkg::OP_BIT_TEST: begin
                            pendRd_d   = 1'b1;
                            pendTest_d = (req.op == io_space_pkg::OP_BIT_TEST);
                            pendTgt_d  = dec.tgt;
                            pendBit_d  = req.bitSel;
                            ioRead_d   = (dec.tgt == io_space_pkg::TGT_IO)
                                      || (dec.tgt == io_space_pkg::TGT_EXTIO);
                            sramRead_d = (dec.tgt == io_space_pkg::TGT_SRAM);
                            xmemRead_d = (dec.tgt == io_space_pkg::TGT_EXTERNAL_MEMORY_BUS);
                        end
                        io_space_pkg::OP_STORE, io_space_pkg::OP_PORT_OUT: begin
                            // peripheral decides which bits are w1c flags
                            ioWrite_d   = (dec.tgt == io_space_pkg::TGT_IO)
                                       || (dec.tgt == io_space_pkg::TGT_EXTIO);
                            sramWrite_d = (dec.tgt == io_space_pkg::TGT_SRAM);
                            xmemWrite_d = (dec.tgt == io_space_pkg::TGT_EXTERNAL_MEMORY_BUS);
                            rspValid_d  = 1'b1;
                        end
                        io_space_pkg::OP_BIT_SET, io_space_pkg::OP_BIT_CLR: begin
                            if (dec.tgt == io_space_pkg::TGT_IO) begin
                                ioRead_d = 1'b1;
                                rmwBit_d = req.bitSel;
                                rmwSet_d = (req.op == io_space_pkg::OP_BIT_SET);
                                rmwIdx_d = dec.ioIndex;
                                state_d  = io_space_pkg::ST_READ;
                            end else begin
                                rspValid_d = 1'b1; // no effect outside the window
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            io_space_pkg::ST_READ: begin
                rmwData_d = bitMerge(ioRdata, rmwBit_q, rmwSet_q);
                state_d   = io_space_pkg::ST_WRITE;
            end
            io_space_pkg::ST_WRITE: begin
                ioIndex_d  = rmwIdx_q;
                ioWdata_d  = rmwData_q; // w1cMask flags read as one clear here
                ioWrite_d  = 1'b1;
                rspValid_d = 1'b1;
                state_d    = io_space_pkg::ST_IDLE;
            end
            default: state_d = io_space_pkg::ST_IDLE;
        endcase
    end

    // ready only when no sequence or read return is in flight
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= io_space_pkg::ST_IDLE;
            rmwData_q  <= `RESET_BYTE;
            rmwBit_q   <= 3'h0;
            rmwSet_q   <= 1'b0;
            rmwIdx_q   <= `RESET_BYTE;
            pendRd_q   <= 1'b0;
            pendTest_q <= 1'b0;
            pendTgt_q  <= io_space_pkg::TGT_NONE;
            pendBit_q  <= 3'h0;
            reqReady   <= 1'b0;
            rspValid   <= 1'b0;
            rspData    <= `RESET_BYTE;
            rspBitTrue <= 1'b0;
            ioRead     <= 1'b0;
            ioWrite    <= 1'b0;
            ioIndex    <= `RESET_BYTE;
            ioWdata    <= `RESET_BYTE;
            sramRead   <= 1'b0;
            sramWrite  <= 1'b0;
            xmemRead   <= 1'b0;
            xmemWrite  <= 1'b0;
            memAddr    <= `RESET_ADDR;
            memWdata   <= `RESET_BYTE;
        end else begin
            state_q    <= state_d;
            rmwData_q  <= rmwData_d;
            rmwBit_q   <= rmwBit_d;
            rmwSet_q   <= rmwSet_d;
            rmwIdx_q   <= rmwIdx_d;
            pendRd_q   <= pendRd_d;
            pendTest_q <= pendTest_d;
            pendTgt_q  <= pendTgt_d;
            pendBit_q  <= pendBit_d;
            reqReady   <= (state_d == io_space_pkg::ST_IDLE) && !pendRd_d;
            rspValid   <= rspValid_d;
            rspData    <= rspData_d;
            rspBitTrue <= rspBitTrue_d;
            ioRead     <= ioRead_d;
            ioWrite    <= ioWrite_d;
            ioIndex    <= ioIndex_d;
            ioWdata    <= ioWdata_d;
            sramRead   <= sramRead_d;
            sramWrite  <= sramWrite_d;
            xmemRead   <= xmemRead_d;
            xmemWrite  <= xmemWrite_d;
            memAddr    <= memAddr_d;
            memWdata   <= memWdata_d;
        end
    end
endmodule : io_space_decoder

// >>> io_space_address_decode_props.sv
// checker for the peripheral space decoder, watching its ports only
// assumes a request is taken at an edge where reqReady and reqValid are high
`timescale 1ns/1ps
module io_space_address_decode_props (
    input wire logic               clk_sys,
    input wire logic               rst_b,
    input io_space_pkg::core_req_t req,
    input wire logic               reqValid,
    input wire logic               compatMode,
    input wire logic               xmemEnable,
    input wire logic               reqReady,
    input wire logic               rspValid,
    input wire logic               ioRead,
    input wire logic               ioWrite,
    input wire logic [7:0]         ioIndex,
    input wire logic               sramRead,
    input wire logic               sramWrite,
    input wire logic               xmemRead,
    input wire logic               xmemWrite,
    input wire logic [15:0]        memAddr
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic dataOp, portOp, bitRmw, ioWin, anyIo, anyMem;
    // taken-request decode, so each property stays short
    always_comb begin
        dataOp = reqReady && reqValid && req.op inside {io_space_pkg::OP_LOAD, io_space_pkg::OP_STORE};
        portOp = reqReady && reqValid && req.op inside {io_space_pkg::OP_PORT_IN, io_space_pkg::OP_PORT_OUT};
        bitRmw = reqReady && reqValid && req.op inside {io_space_pkg::OP_BIT_SET, io_space_pkg::OP_BIT_CLR};
        ioWin  = req.addr inside {[16'h0020:16'h005F]};
        anyIo  = ioRead || ioWrite;
        anyMem = sramRead || sramWrite || xmemRead || xmemWrite;
    end
    a_data_io_index: assert property (dataOp && ioWin |=> anyIo && ioIndex == 8'($past(req.addr) - 16'h0020))
        else $error("peripheral data access at wrong index");
    a_store_done_next: assert property (dataOp && ioWin && req.op == io_space_pkg::OP_STORE |=> ioWrite && rspValid)
        else $error("peripheral store not done next cycle");
    a_load_two_cycles: assert property (dataOp && ioWin && req.op == io_space_pkg::OP_LOAD |=> ioRead && !rspValid ##1 rspValid)
        else $error("peripheral load answer late or early");
    a_port_in_window: assert property (portOp && req.addr <= 16'h003F |=> anyIo && ioIndex == 8'($past(req.addr)))
        else $error("port access not at its index");
    a_port_above_drop: assert property (portOp && req.addr > 16'h003F |=> !anyIo && !anyMem)
        else $error("port access above window reached a target");
    a_bit_rmw_order: assert property (bitRmw && req.addr <= 16'h001F |=> ioRead ##1 !ioWrite ##1 (ioWrite && rspValid))
        else $error("bit update not read then written back");
    a_bit_outside_none: assert property (bitRmw && req.addr > 16'h001F |=> rspValid && !anyIo ##1 !anyIo)
        else $error("bit update outside lower window touched a register");
    a_compat_to_sram: assert property (dataOp && compatMode && req.addr inside {[16'h0060:16'h00FF]}
        |=> !anyIo && (sramRead || sramWrite) && memAddr == $past(req.addr))
        else $error("extended window not plain memory in legacy mode");
    a_external_memory_bus_routed: assert property (dataOp && xmemEnable && req.addr > 16'h04FF |=> (xmemRead || xmemWrite) && memAddr == $past(req.addr))
        else $error("high address not sent to external bus");
    a_no_alias_off: assert property (dataOp && !xmemEnable && req.addr > 16'h04FF |=> !anyMem && !anyIo)
        else $error("high address aliased with external bus off");
    c_bit_rmw: cover property (bitRmw ##1 ioRead ##2 ioWrite);
    c_external_memory_bus_write: cover property (xmemWrite);
    c_compat_store: cover property (compatMode && sramWrite);
endmodule : io_space_address_decode_props
bind io_space_decoder io_space_address_decode_props chk (.clk_sys(clk_sys), .rst_b(rst_b), .req(req),
    .reqValid(reqValid), .compatMode(compatMode), .xmemEnable(xmemEnable), .reqReady(reqReady),
    .rspValid(rspValid), .ioRead(ioRead), .ioWrite(ioWrite), .ioIndex(ioIndex), .sramRead(sramRead),
    .sramWrite(sramWrite), .xmemRead(xmemRead), .xmemWrite(xmemWrite), .memAddr(memAddr));

// >>> io_mem_model.sv
// far side model: peripheral registers and data memory behind the decoder
// assumes strobes are one-cycle pulses with index and address held after
`timescale 1ns/1ps
module io_mem_model (
    input wire logic        clk_sys,
    input wire logic        ioWrite,
    input wire logic [7:0]  ioIndex,
    input wire logic [7:0]  ioWdata,
    input wire logic        sramRead,
    input wire logic        sramWrite,
    input wire logic        xmemRead,
    input wire logic        xmemWrite,
    input wire logic [15:0] memAddr,
    input wire logic [7:0]  memWdata,
    output logic [7:0]      ioRdata,
    output logic            ioPresent,
    output logic [7:0]      w1cMask,
    output logic [7:0]      sramRdata,
    output logic [7:0]      xmemRdata
);
    logic [7:0] io [0:255];
    logic [7:0] mem [0:65535];
    logic       sramRdQ, xmemRdQ;
    initial begin
        for (int i = 0; i < 256; i++) io[i] = 8'(i) ^ 8'h5A;
        for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
    end
    // memory read data only valid around a read; otherwise inverted junk, never the last value
    always_comb begin
        ioPresent = ioIndex != 8'h3B;
        ioRdata   = ioPresent ? io[ioIndex] : 8'hA5;
        w1cMask   = ioIndex == 8'h08 ? 8'hF0 : 8'h00;
        sramRdata = (sramRead || sramRdQ) ? mem[memAddr] : ~mem[memAddr];
        xmemRdata = (xmemRead || xmemRdQ) ? mem[memAddr] : ~mem[memAddr];
    end
    // flag bits clear on a written one and keep their state on a written zero
    always @(posedge clk_sys) begin
        {sramRdQ, xmemRdQ} <= {sramRead, xmemRead};
        if (ioWrite) io[ioIndex] <= (ioWdata & ~w1cMask) | (io[ioIndex] & w1cMask & ~ioWdata);
        if (sramWrite || xmemWrite) mem[memAddr] <= memWdata;
    end
endmodule : io_mem_model

// >>> io_space_address_decode_bench.sv
// self-checking bench for the peripheral space decoder
// assumes io_mem_model stands in for the peripherals and data memory
`timescale 1ns/1ps
`include "io_space_params.svh"
module io_space_address_decode_bench;
    localparam io_space_pkg::access_op_t LD = io_space_pkg::OP_LOAD;
    localparam io_space_pkg::access_op_t ST = io_space_pkg::OP_STORE;
    localparam io_space_pkg::access_op_t PI = io_space_pkg::OP_PORT_IN;
    localparam io_space_pkg::access_op_t PO = io_space_pkg::OP_PORT_OUT;
    localparam io_space_pkg::access_op_t BS = io_space_pkg::OP_BIT_SET;
    localparam io_space_pkg::access_op_t BC = io_space_pkg::OP_BIT_CLR;
    localparam io_space_pkg::access_op_t BT = io_space_pkg::OP_BIT_TEST;
    logic clk_sys = 1'b0, rst_b = 1'b0, reqValid = 1'b0, compatMode = 1'b0, xmemEnable = 1'b0;
    io_space_pkg::core_req_t req = '0;
    logic [7:0]  ioRdata, w1cMask, sramRdata, xmemRdata, rspData, ioIndex, ioWdata, memWdata;
    logic        ioPresent, reqReady, rspValid, rspBitTrue, ioRead, ioWrite;
    logic        sramRead, sramWrite, xmemRead, xmemWrite;
    logic [15:0] memAddr;
    logic [31:0] lfsrQ = 32'h6E09;
    logic [7:0]  refIo [0:255];
    logic [7:0]  refMem [int];
    int          n_fail = 0;
    int          num_checks = 0;
    always #10 clk_sys = ~clk_sys;
    io_space_decoder uut (.clk_sys(clk_sys), .rst_b(rst_b), .req(req), .reqValid(reqValid),
        .compatMode(compatMode), .xmemEnable(xmemEnable), .ioRdata(ioRdata), .ioPresent(ioPresent),
        .w1cMask(w1cMask), .sramRdata(sramRdata), .xmemRdata(xmemRdata), .reqReady(reqReady),
        .rspValid(rspValid), .rspData(rspData), .rspBitTrue(rspBitTrue), .ioRead(ioRead),
        .ioWrite(ioWrite), .ioIndex(ioIndex), .ioWdata(ioWdata), .sramRead(sramRead),
        .sramWrite(sramWrite), .xmemRead(xmemRead), .xmemWrite(xmemWrite), .memAddr(memAddr),
        .memWdata(memWdata));
    io_mem_model pm (.clk_sys(clk_sys), .ioWrite(ioWrite), .ioIndex(ioIndex), .ioWdata(ioWdata),
        .sramRead(sramRead), .sramWrite(sramWrite), .xmemRead(xmemRead), .xmemWrite(xmemWrite),
        .memAddr(memAddr), .memWdata(memWdata), .ioRdata(ioRdata), .ioPresent(ioPresent),
        .w1cMask(w1cMask), .sramRdata(sramRdata), .xmemRdata(xmemRdata));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    function automatic logic [31:0] rnd();
        lfsrQ = {lfsrQ[30:0], lfsrQ[31] ^ lfsrQ[21] ^ lfsrQ[1] ^ lfsrQ[0]};
        return lfsrQ;
    endfunction : rnd
    // 0 nothing, 1 peripheral, 2 internal memory, 3 external bus
    function automatic int tgt(input io_space_pkg::access_op_t op, input logic [15:0] a);
        if (op inside {PI, PO}) return (a <= 16'h003F) ? 1 : 0;
        if (!(op inside {LD, ST})) return (a <= 16'h001F) ? 1 : 0;
        if (a < `IO_DATA_FIRST) return 0;
        if (a <= `IO_DATA_LAST || (a <= `EXT_IO_LAST && !compatMode)) return 1;
        if (a <= (compatMode ? `SRAM_LAST_COMPAT : `SRAM_LAST)) return 2;
        return xmemEnable ? 3 : 0;
    endfunction : tgt
    // one request, strobes gathered until the answer, then compared with the model
    task automatic access(input io_space_pkg::access_op_t op, input logic [15:0] a,
                          input logic [7:0] wd, input logic [2:0] b);
        int t, k, lat;
        logic [7:0] idx, rd, nv, m, wSeen;
        logic [5:0] want, seen;
        logic [15:0] where;
        logic isWr;
        t = tgt(op, a);
        idx = (op inside {LD, ST}) ? 8'(a - `IO_DATA_OFFSET) : a[7:0];
        isWr = op inside {ST, PO, BS, BC};
        m = idx == 8'h08 ? 8'hF0 : 8'h00;
        rd = (t == 1 && idx != 8'h3B) ? refIo[idx] : 8'h00;
        if (t > 1 && refMem.exists(a)) rd = refMem[a];
        nv = op == BS ? rd | (8'h01 << b) : op == BC ? rd & ~(8'h01 << b) : wd;
        lat = (op inside {BS, BC}) ? (t == 1 ? 3 : 1) : t == 0 ? 0 : isWr ? 1 : 2;
        want = t == 1 ? (op inside {BS, BC} ? 6'h30 : isWr ? 6'h10 : 6'h20) :
               t == 2 ? (isWr ? 6'h04 : 6'h08) : t == 3 ? (isWr ? 6'h01 : 6'h02) : 6'h00;
        seen = 6'h00;
        where = 16'h0000;
        wSeen = 8'h00;
        for (k = 0; k < 20 && reqReady !== 1'b1; k++) @(posedge clk_sys) #1;
        if (reqReady !== 1'b1) begin
            n_fail++;
            print_verdict();
        end
        req = '{op, a, wd, b};
        reqValid = 1'b1;
        @(posedge clk_sys) #1;
        reqValid = 1'b0;
        for (k = 1; k < 10; k++) begin
            seen |= {ioRead, ioWrite, sramRead, sramWrite, xmemRead, xmemWrite};
            if (ioRead || ioWrite) where = {8'h00, ioIndex};
            if (sramRead || sramWrite || xmemRead || xmemWrite) where = memAddr;
            if (ioWrite) wSeen = ioWdata;
            if (sramWrite || xmemWrite) wSeen = memWdata;
            if (rspValid === 1'b1) break;
            @(posedge clk_sys) #1;
        end
        if (k == 10) begin
            n_fail++;
            print_verdict();
        end
        if (lat != 0) check(16'(k), 16'(lat));
        check({10'h000, seen}, {10'h000, want});
        if (t != 0) check(where, t == 1 ? {8'h00, idx} : a);
        if (isWr && t != 0) check(wSeen, nv);
        if (op inside {LD, PI}) check(rspData, rd);
        if (op == BT) check(rspBitTrue, t == 1 ? rd[b] : 1'b0);
        if (isWr && t == 1) refIo[idx] = (nv & ~m) | (rd & m & ~nv);
        if (isWr && t > 1) refMem[a] = wd;
        // idle edge: reqValid must not fall and rise again in one time step
        @(posedge clk_sys) #1;
    endtask : access
    initial begin
        logic [31:0] r;
        io_space_pkg::access_op_t op;
        logic [15:0] a;
        for (int i = 0; i < 256; i++) refIo[i] = 8'(i) ^ 8'h5A;
        repeat (12) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        // flag register: zero write keeps flags, bit update clears them
        access(ST, 16'h0028, 8'h00, 3'h0);
        access(LD, 16'h0028, 8'h00, 3'h0);
        access(BS, 16'h0008, 8'h00, 3'h1);
        access(LD, 16'h0028, 8'h00, 3'h0);
        access(PO, 16'h003F, 8'hC3, 3'h0);
        access(PI, 16'h003F, 8'h00, 3'h0);
        access(PI, 16'h0040, 8'h00, 3'h0);
        access(BC, 16'h0020, 8'h00, 3'h0);
        for (int i = 0; i < 8; i++) access(BT, 16'h001F, 8'h00, 3'(i));
        access(LD, 16'h005B, 8'h00, 3'h0);
        access(LD, 16'h0010, 8'h00, 3'h0);
        for (int md = 0; md < 4; md++) begin
            {compatMode, xmemEnable} = 2'(md);
            for (int j = 0; j < 3; j++) begin
                a = j == 0 ? 16'h00A0 : j == 1 ? 16'h0460 : 16'h0600;
                access(ST, a, 8'(md * 16 + j), 3'h0);
                access(LD, a, 8'h00, 3'h0);
            end
        end
        // random traffic across the low 2K of data space and all modes
        for (int n = 0; n < 300; n++) begin
            r = rnd();
            {compatMode, xmemEnable} = r[31:30];
            op = io_space_pkg::access_op_t'(3'(r[29:27] % 7 + 1));
            a = r[26] ? {8'h00, r[7:0]} : {5'h00, r[10:0]};
            if (op inside {ST, PO, BS, BC} && a == (op == ST ? 16'h005B : 16'h003B)) continue;
            access(op, a, r[15:8], r[18:16]);
        end
        print_verdict();
    end
endmodule : io_space_address_decode_bench
